/* src/bmc_boot_ctrl.sv */
// module-level control: boot mode straps, boot chip select, timers,
// output three-state control and the shared scan chain
// assumes straps fixed on the board, test clock unrelated to clk_in
`timescale 1ns/100ps
module bmc_boot_ctrl
   import bmc_pkg::*;
#(
   parameter int NP = bmc_pkg::NUM_PROC,
   parameter int TW = bmc_pkg::TIMER_W
) (
   input  wire logic                 clk_in,
   input  wire logic                 rst_in,
   input  wire bmc_pkg::bmc_strap_type strap_in,
   input  wire logic                 bus_master_in,
   input  wire logic                 suspend_bus_three_state_in,
   input  wire logic                 boot_cs_req_in,
   input  wire logic                 boot_byte_strobe_in,
   input  wire logic [bmc_pkg::EPROM_W-1:0] eprom_data_in,
   input  wire logic [NP-1:0]        timer_enable_in,
   input  wire logic [TW-1:0]        timer_period_in,
   input  wire logic                 tck_in,
   input  wire logic                 trst_n_in,
   input  wire logic                 tms_in,
   input  wire logic                 tdi_in,
   output bmc_pkg::bmc_status_type   boot_status_out,
   output logic                      boot_memory_select_n_out,
   output logic                      boot_memory_select_oe_n_out,
   output logic [bmc_pkg::EPROM_W-1:0] boot_byte_out,
   output logic                      boot_byte_valid_out,
   output logic [NP-1:0]             proc_reset_out,
   output logic                      bus_oe_n_out,
   output logic [NP-1:0]             timer_expired_out,
   output logic                      tdo_out,
   output logic                      tdo_oe_n_out
);
   import bmc_pkg::*;

   // boot mode capture and output control
   bmc_status_type        stat_r,   stat_nxt;
   logic                  cs_n_r,   cs_n_nxt;
   logic                  cs_oe_n_r, cs_oe_n_nxt;
   logic                  bus_oe_n_r, bus_oe_n_nxt;
   logic [NP-1:0]         prst_r,   prst_nxt;
   logic [EPROM_W-1:0]    byte_r,   byte_nxt;
   logic                  bval_r,   bval_nxt;
   logic                  cs_drive;

   always_comb begin
      stat_nxt = stat_r;
      if (rst_in) begin
         stat_nxt = bmc_decode(strap_in);
      end
      // chip select driven only in eprom mode by the bus master
      cs_drive = (stat_r.mode == BMC_BOOT_EPROM) && !stat_r.reserved &&
                 bus_master_in && !suspend_bus_three_state_in &&
                 !rst_in;
      cs_oe_n_nxt  = !cs_drive;
      cs_n_nxt     = !(cs_drive && boot_cs_req_in);
      bus_oe_n_nxt = suspend_bus_three_state_in ||
                     !bus_master_in || rst_in;
      prst_nxt     = rst_in ? {NP{1'b1}} : {NP{1'b0}};
      byte_nxt     = byte_r;
      bval_nxt     = 1'b0;
      // take a byte only once the chip select stands low at the pin
      if (cs_drive && boot_cs_req_in && boot_byte_strobe_in &&
          !cs_n_r && !cs_oe_n_r) begin
         byte_nxt = eprom_data_in;
         bval_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         stat_r     <= stat_nxt;
         cs_n_r     <= 1'b1;
         cs_oe_n_r  <= 1'b1;
         bus_oe_n_r <= 1'b1;
         prst_r     <= {NP{1'b1}};
         byte_r     <= '0;
         bval_r     <= 1'b0;
      end else begin
         stat_r     <= stat_nxt;
         cs_n_r     <= cs_n_nxt;
         cs_oe_n_r  <= cs_oe_n_nxt;
         bus_oe_n_r <= bus_oe_n_nxt;
         prst_r     <= prst_nxt;
         byte_r     <= byte_nxt;
         bval_r     <= bval_nxt;
      end
   end

   assign boot_status_out             = stat_r;
   assign boot_memory_select_n_out    = cs_n_r;
   assign boot_memory_select_oe_n_out = cs_oe_n_r;
   assign boot_byte_out               = byte_r;
   assign boot_byte_valid_out         = bval_r;
   assign proc_reset_out              = prst_r;
   assign bus_oe_n_out                = bus_oe_n_r;

   // one timer per processor, all on the common clock
   genvar gi;
   generate
      for (gi = 0; gi < NP; gi++) begin : g_timer
         bmc_timer_pulse #(
            .W (TW)
         ) u_timer (
            .clk_in                (clk_in),
            .rst_in                (rst_in),
            .enable_in             (timer_enable_in[gi]),
            .period_in             (timer_period_in),
            .timer_count_value_out (),
            .timer_expired_out     (timer_expired_out[gi])
         );
      end
   endgenerate

   // scan state machine and chain, on the test clock
   bmc_tap_state_type  tap_r,   tap_nxt;
   logic [CHAIN_W-1:0] chain_r, chain_nxt;
   logic               tdo_r,   tdo_nxt;
   logic               toe_r,   toe_nxt;

   always_comb begin
      tap_nxt = tap_r;
      case (tap_r)
         BMC_TLR:      tap_nxt = tms_in ? BMC_TLR      : BMC_RTI;
         BMC_RTI:      tap_nxt = tms_in ? BMC_SEL_DR   : BMC_RTI;
         BMC_SEL_DR:   tap_nxt = tms_in ? BMC_SEL_IR   : BMC_CAP_DR;
         BMC_CAP_DR:   tap_nxt = tms_in ? BMC_EXIT1_DR : BMC_SHIFT_DR;
         BMC_SHIFT_DR: tap_nxt = tms_in ? BMC_EXIT1_DR : BMC_SHIFT_DR;
         BMC_EXIT1_DR: tap_nxt = tms_in ? BMC_UPD_DR   : BMC_PAUSE_DR;
         BMC_PAUSE_DR: tap_nxt = tms_in ? BMC_EXIT2_DR : BMC_PAUSE_DR;
         BMC_EXIT2_DR: tap_nxt = tms_in ? BMC_UPD_DR   : BMC_SHIFT_DR;
         BMC_UPD_DR:   tap_nxt = tms_in ? BMC_SEL_DR   : BMC_RTI;
         BMC_SEL_IR:   tap_nxt = tms_in ? BMC_TLR      : BMC_CAP_IR;
         BMC_CAP_IR:   tap_nxt = tms_in ? BMC_EXIT1_IR : BMC_SHIFT_IR;
         BMC_SHIFT_IR: tap_nxt = tms_in ? BMC_EXIT1_IR : BMC_SHIFT_IR;
         BMC_EXIT1_IR: tap_nxt = tms_in ? BMC_UPD_IR   : BMC_PAUSE_IR;
         BMC_PAUSE_IR: tap_nxt = tms_in ? BMC_EXIT2_IR : BMC_PAUSE_IR;
         BMC_EXIT2_IR: tap_nxt = tms_in ? BMC_UPD_IR   : BMC_SHIFT_IR;
         BMC_UPD_IR:   tap_nxt = tms_in ? BMC_SEL_DR   : BMC_RTI;
         default:      tap_nxt = BMC_TLR;
      endcase
      chain_nxt = chain_r;
      tdo_nxt   = tdo_r;
      toe_nxt   = 1'b1;
      if (tap_r == BMC_CAP_DR || tap_r == BMC_CAP_IR) begin
         chain_nxt = '0;
      end else if (tap_r == BMC_SHIFT_DR || tap_r == BMC_SHIFT_IR) begin
         // bit 0 is processor a, top bit processor d
         chain_nxt = {chain_r[CHAIN_W-2:0], tdi_in};
         tdo_nxt   = chain_r[CHAIN_W-1];
         toe_nxt   = 1'b0;
      end
   end

   always_ff @(posedge tck_in or negedge trst_n_in) begin
      if (!trst_n_in) begin
         tap_r   <= BMC_TLR;
         chain_r <= '0;
         tdo_r   <= 1'b0;
         toe_r   <= 1'b1;
      end else begin
         tap_r   <= tap_nxt;
         chain_r <= chain_nxt;
         tdo_r   <= tdo_nxt;
         toe_r   <= toe_nxt;
      end
   end

   assign tdo_out      = tdo_r;
   assign tdo_oe_n_out = toe_r;

   // checks on the system clock
   sequence in_reset_s;
      rst_in;
   endsequence

   sequence released_s;
      rst_in ##1 !rst_in;
   endsequence

   mode_decode_a: assert property (@(posedge clk_in)
      in_reset_s |=> stat_r == bmc_decode($past(strap_in)))
      else $error("boot mode does not match straps");
   mode_hold_a: assert property (@(posedge clk_in)
      !rst_in |=> $stable(stat_r))
      else $error("boot mode changed outside reset");
   cs_mode_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !cs_oe_n_r |-> $past(stat_r.mode) == BMC_BOOT_EPROM)
      else $error("boot select driven outside eprom mode");
   cs_master_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !bus_master_in |=> cs_oe_n_r && cs_n_r)
      else $error("boot select driven by a bus slave");
   cs_follow_a: assert property (@(posedge clk_in) disable iff (rst_in)
      (stat_r.mode == BMC_BOOT_EPROM && !stat_r.reserved && bus_master_in &&
       !suspend_bus_three_state_in && boot_cs_req_in)
      |=> !cs_n_r && !cs_oe_n_r)
      else $error("eprom chip select not asserted");
   bus_float_a: assert property (@(posedge clk_in)
      (suspend_bus_three_state_in || !bus_master_in) |=> bus_oe_n_r)
      else $error("outputs driven while suspended or slave");
   proc_reset_a: assert property (@(posedge clk_in)
      in_reset_s |=> &prst_r)
      else $error("processors not held in reset");
   proc_run_a: assert property (@(posedge clk_in)
      released_s |=> prst_r == '0)
      else $error("processor reset not released");

   // checks on the test clock
   tap_reset_a: assert property (@(posedge tck_in) disable iff (!trst_n_in)
      tms_in [*5] |=> tap_r == BMC_TLR)
      else $error("five tms highs did not reach test reset");
   chain_path_a: assert property (@(posedge tck_in) disable iff (!trst_n_in)
      (tap_r == BMC_SHIFT_DR) [*4] |=> chain_r[CHAIN_W-1] == $past(tdi_in, 4))
      else $error("scan chain is not four stages a to d");
endmodule : bmc_boot_ctrl

/* src/bmc_timer_pulse.sv */
// shared package and the per-processor timer-expired pulse generator
// assumes one 100 MHz clock, synchronous active-high reset, straps held still
//
// Overview of operation
// - eprom select 1, link select 0: eprom boot, drive chip select out
// - selects 0 0 with boot memory select high: host processor boot
// - eprom 0, link 1, boot memory select high: link port boot
// - selects 0 0 with boot memory select low: no boot, run external
// - timer expired output high four cycles when enabled count reaches 0
// - all four processors run from the one common input clock
// - reset held at power-up; processors held in known state meanwhile
// - test reset and mode select drive one shared scan state machine
// - scan chain enters at processor a, leaves from processor d
// - scan logic clocked by its own test clock, shared by all four
// - three-state outputs other than test data out float on suspend or while module is bus slave
// - boot memory select is driven only in eprom boot mode, three-stated otherwise
// - only the bus master drives the boot memory select output
// - eprom boot reads an eight-bit wide eprom

package bmc_pkg;
   localparam int          NUM_PROC         = 4;
   localparam int          TIMER_W          = 32;
   localparam int          EPROM_W          = 8;
   localparam int          PULSE_W          = 3;
   localparam int          CLK_PERIOD_NS    = 10;
   localparam int          PULSE_CYCLES     = 4;
   localparam int          CHAIN_W          = NUM_PROC;
   localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(PULSE_CYCLES);

   typedef enum logic [1:0] {
      BMC_BOOT_EPROM,
      BMC_BOOT_HOST,
      BMC_BOOT_LINK,
      BMC_BOOT_NONE
   } bmc_boot_mode_type;

   typedef enum logic [3:0] {
      BMC_TLR, BMC_RTI, BMC_SEL_DR, BMC_CAP_DR, BMC_SHIFT_DR, BMC_EXIT1_DR,
      BMC_PAUSE_DR, BMC_EXIT2_DR, BMC_UPD_DR, BMC_SEL_IR, BMC_CAP_IR,
      BMC_SHIFT_IR, BMC_EXIT1_IR, BMC_PAUSE_IR, BMC_EXIT2_IR, BMC_UPD_IR
   } bmc_tap_state_type;

   typedef struct packed {
      logic eprom_boot_select;
      logic link_boot_select;
      logic boot_memory_select;
   } bmc_strap_type;

   typedef struct packed {
      bmc_boot_mode_type mode;
      logic              reserved;
   } bmc_status_type;

   function automatic bmc_status_type bmc_decode(input bmc_strap_type s);
      bmc_status_type r;
      r.reserved = 1'b0;
      r.mode     = BMC_BOOT_NONE;
      if (s.eprom_boot_select && !s.link_boot_select)
         r.mode = BMC_BOOT_EPROM;
      else if (!s.eprom_boot_select && !s.link_boot_select)
         r.mode = s.boot_memory_select ? BMC_BOOT_HOST
                                       : BMC_BOOT_NONE;
      else if (!s.eprom_boot_select && s.boot_memory_select)
         r.mode = BMC_BOOT_LINK;
      else
         r.reserved = 1'b1;
      return r;
   endfunction : bmc_decode
endpackage : bmc_pkg

`timescale 1ns/100ps
module bmc_timer_pulse #(
   parameter int W = bmc_pkg::TIMER_W
) (
   input  wire logic         clk_in,
   input  wire logic         rst_in,
   input  wire logic         enable_in,
   input  wire logic [W-1:0] period_in,
   output logic      [W-1:0] timer_count_value_out,
   output logic              timer_expired_out
);
   import bmc_pkg::*;

   logic [W-1:0]       count_r, count_nxt;
   logic [PULSE_W-1:0] pulse_r, pulse_nxt;
   logic               exp_r,   exp_nxt;
   logic               hit;

   always_comb begin
      hit       = enable_in && (count_r == W'(1));
      count_nxt = count_r;
      if (enable_in) begin
         count_nxt = (count_r == '0) ? period_in : count_r - W'(1);
      end
      if (hit) begin
         pulse_nxt = PULSE_LOAD;
      end else if (pulse_r != '0) begin
         pulse_nxt = pulse_r - PULSE_W'(1);
      end else begin
         pulse_nxt = '0;
      end
      exp_nxt = (pulse_nxt != '0);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         count_r <= '0;
         pulse_r <= '0;
         exp_r   <= 1'b0;
      end else begin
         count_r <= count_nxt;
         pulse_r <= pulse_nxt;
         exp_r   <= exp_nxt;
      end
   end

   assign timer_count_value_out = count_r;
   assign timer_expired_out     = exp_r;

   sequence zero_reached_s;
      enable_in && count_r == W'(1);
   endsequence

   timer_four_a: assert property (@(posedge clk_in) disable iff (rst_in)
      zero_reached_s |=> exp_r [*4] ##1
         (!exp_r || $past(hit) || $past(hit, 2) || $past(hit, 3) ||
          $past(hit, 4)))
      else $error("timer expired pulse not four cycles");
   timer_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
      !($past(hit) || $past(hit, 2) || $past(hit, 3) || $past(hit, 4))
      |-> !exp_r)
      else $error("timer expired without count reaching zero");
endmodule : bmc_timer_pulse

/* test/bmc_eprom_model.sv */
// far-side boot eprom: byte pattern while selected, junk while released
// assumes the bench advances the byte address with its strobe
`timescale 1ns/100ps
module bmc_eprom_model (
   input  wire logic                        clk_in,
   input  wire logic                        cs_n_in,
   input  wire logic                        oe_n_in,
   input  wire logic                        next_in,
   output logic     [bmc_pkg::EPROM_W-1:0] data_out
);
   logic [bmc_pkg::EPROM_W-1:0] addr_r = 8'h00;
   logic [bmc_pkg::EPROM_W-1:0] last_r = 8'h00;
   logic                        sel;

   // answers only while chip select is really driven low
   assign sel = !cs_n_in && !oe_n_in;
   // one byte-wide word per address, inverted last byte when released
   assign data_out = sel ? (addr_r ^ 8'hA5) : ~last_r;

   always @(posedge clk_in) begin
      if (sel)
         last_r <= data_out;
      if (sel && next_in)
         addr_r <= addr_r + 8'h01;
   end
endmodule : bmc_eprom_model

/* test/bmc_boot_ctrl_tb.sv */
// self-checking bench: strap decode, chip select, bus enable, timers, scan
// assumes the eprom model is compiled before this file
`timescale 1ns/100ps
module bmc_boot_ctrl_tb;
   import bmc_pkg::*;
   logic           clk_in = 0, rst_in = 1, tck = 0, trst_n = 1;
   logic           bus_master = 0, suspend = 0, cs_req = 0, strobe = 0;
   logic           tms = 1, tdi = 0, run = 0, tdo_m;
   logic [3:0]     ten = 4'h0, ch, preset, texp, e_rst;
   logic [31:0]    tper = 32'h3;
   bmc_strap_type  strap = 3'h4;
   bmc_status_type st_o, st_m;
   logic [7:0]     edata, byte_o, e_byte;
   logic           cs_n, cs_oe_n, bval, bus_oe_n, tdo, tdo_oe_n;
   logic           e_cs_n, e_oe_n, e_bus, e_val;
   int             cnt[4] = '{0, 0, 0, 0}, ex[4] = '{0, 0, 0, 0};
   int             bad_count = 0, total_checks = 0;

   always #5 clk_in = ~clk_in;

   bmc_boot_ctrl DUT (.clk_in(clk_in), .rst_in(rst_in), .strap_in(strap),
      .bus_master_in(bus_master), .suspend_bus_three_state_in(suspend),
      .boot_cs_req_in(cs_req), .boot_byte_strobe_in(strobe),
      .eprom_data_in(edata), .timer_enable_in(ten),
      .timer_period_in(tper), .tck_in(tck), .trst_n_in(trst_n),
      .tms_in(tms), .tdi_in(tdi), .boot_status_out(st_o),
      .boot_memory_select_n_out(cs_n),
      .boot_memory_select_oe_n_out(cs_oe_n), .boot_byte_out(byte_o),
      .boot_byte_valid_out(bval), .proc_reset_out(preset),
      .bus_oe_n_out(bus_oe_n), .timer_expired_out(texp), .tdo_out(tdo),
      .tdo_oe_n_out(tdo_oe_n));

   bmc_eprom_model u_eprom (.clk_in(clk_in), .cs_n_in(cs_n),
      .oe_n_in(cs_oe_n), .next_in(strobe), .data_out(edata));

   function automatic bmc_status_type dec(input bmc_strap_type s);
      bmc_status_type r;
      r.mode = BMC_BOOT_NONE;
      r.reserved = 1'h0;
      case (s)
         3'h4, 3'h5: r.mode = BMC_BOOT_EPROM;
         3'h1: r.mode = BMC_BOOT_HOST;
         3'h3: r.mode = BMC_BOOT_LINK;
         3'h0: r.mode = BMC_BOOT_NONE;
         default: r.reserved = 1'h1;
      endcase
      return r;
   endfunction : dec

   task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_v

   task automatic chk_st(input bmc_status_type g, input bmc_status_type e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR at %0t: status %h expected %h", $time, g, e);
      end
   endtask : chk_st

   // reference model, updated on every rising edge
   always @(posedge clk_in) begin : model
      logic ok, tk;
      ok = st_m.mode == BMC_BOOT_EPROM && !st_m.reserved && bus_master
           && !suspend && !rst_in;
      tk = ok && cs_req && strobe && !e_cs_n && !e_oe_n;
      if (rst_in)
         st_m <= dec(strap);
      e_oe_n <= !ok;
      e_cs_n <= !(ok && cs_req);
      e_bus <= suspend | !bus_master | rst_in;
      e_val <= tk;
      if (tk)
         e_byte <= edata;
      e_rst <= rst_in ? 4'hF : 4'h0;
      for (int i = 0; i < 4; i++) begin
         if (rst_in) begin
            cnt[i] = 0;
            ex[i] = 0;
         end else begin
            if (ex[i] > 0)
               ex[i]--;
            if (ten[i] && cnt[i] == 1)
               ex[i] = 4;
            if (ten[i])
               cnt[i] = (cnt[i] == 0) ? int'(tper) : cnt[i] - 1;
         end
      end
   end

   always @(negedge clk_in) if (run) begin
      chk_st(st_o, st_m);
      chk_v(cs_oe_n, e_oe_n);
      chk_v(cs_n, e_cs_n);
      chk_v(bus_oe_n, e_bus);
      chk_v(bval, e_val);
      if (e_val)
         chk_v(byte_o, e_byte);
      chk_v(preset, e_rst);
      chk_v(texp, {ex[3] > 0, ex[2] > 0, ex[1] > 0, ex[0] > 0});
   end

   task automatic do_reset(input bmc_strap_type s);
      @(negedge clk_in);
      rst_in = 1'h1;
      strap = s;
      tper = 32'($urandom % 6) + 32'h1;
      repeat (16) @(negedge clk_in);
      rst_in = 1'h0;
   endtask : do_reset

   task automatic traffic(input int n);
      repeat (n) begin
         @(negedge clk_in);
         bus_master = ($urandom % 4) != 0;
         suspend = ($urandom % 5) == 0;
         cs_req = ($urandom % 3) != 0;
         strobe = 1'($urandom);
         if ($urandom % 8 == 0)
            ten = 4'($urandom);
      end
   endtask : traffic

   // one test clock period of 18 ns, unrelated to clk_in
   task automatic tstep(input logic m, input bit sh);
      tms = m;
      tdi = 1'($urandom);
      #7 tck = 1'h1;
      if (sh) begin
         tdo_m = ch[3];
         ch = {ch[2:0], tdi};
      end
      #11 tck = 1'h0;
      if (sh)
         chk_v(tdo, tdo_m);
      chk_v(tdo_oe_n, !sh);
   endtask : tstep

   task automatic give_verdict();
      $display("checks %0d errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   initial begin
      #200000;
      bad_count++;
      $display("ERROR at %0t: run did not finish", $time);
      give_verdict();
   end

   initial begin
      void'($urandom(32'hD871F0F9));
      #2 trst_n = 1'h0;
      do_reset(3'h4);
      trst_n = 1'h1;
      run = 1'h1;
      for (int k = 0; k < 8; k++) begin
         do_reset(bmc_strap_type'(k[2:0]));
         traffic(60);
         strap = ~strap;
         traffic(20);
      end
      repeat (5) tstep(1'h1, 1'b0);
      tstep(1'h0, 1'b0);
      tstep(1'h1, 1'b0);
      tstep(1'h0, 1'b0);
      ch = 4'h0;
      tstep(1'h0, 1'b0);
      for (int i = 0; i < 12; i++)
         tstep(i == 11, 1'b1);
      tstep(1'h1, 1'b0);
      tstep(1'h1, 1'b0);
      tstep(1'h0, 1'b0);
      ch = 4'h0;
      tstep(1'h0, 1'b0);
      repeat (2) tstep(1'h0, 1'b1);
      tstep(1'h1, 1'b1);
      tstep(1'h1, 1'b0);
      tstep(1'h1, 1'b0);
      tstep(1'h1, 1'b0);
      tstep(1'h0, 1'b0);
      ch = 4'h0;
      tstep(1'h0, 1'b0);
      repeat (5) tstep(1'h0, 1'b1);
      trst_n = 1'h0;
      #3;
      chk_v(tdo_oe_n, 1'h1);
      chk_v(tdo, 1'h0);
      trst_n = 1'h1;
      tstep(1'h1, 1'b0);
      give_verdict();
   end
endmodule : bmc_boot_ctrl_tb
